// ### pdc_pkg.sv
/*
  shared constants and carriers of the decimation chain back end: complex
  sample structs, tuner link word layout, register map and timing counts.
  assumes a 25 MHz pclk.
*/
package pdc_pkg;
	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} cplx_type;
	typedef struct packed {
		cplx_type wanted;
		cplx_type image;
	} pair_type;
	typedef enum logic [1:0] {
		ADAPT_IDLE = 2'b00,
		ADAPT_STARTUP = 2'b01,
		ADAPT_TRACK = 2'b10,
		ADAPT_FROZEN = 2'b11
	} adapt_state_type;
	localparam int TAPS = 4;
	localparam int CMD_BITS = 23;
	localparam int REQ_BITS = 7;
	localparam int FRAME_BITS = 30;
	localparam int CMD_RSV_LSB = 18;
	localparam int CMD_A_LSB = 14;
	localparam int CMD_B_LSB = 11;
	localparam int CMD_C_LSB = 9;
	localparam int CMD_D_LSB = 7;
	localparam int CMD_DQ = 6;
	localparam int CMD_DET = 5;
	localparam int CMD_LIN = 4;
	localparam int CMD_INJ = 3;
	localparam int CMD_INJQ = 2;
	localparam int CMD_BW = 1;
	localparam int CMD_BWQ = 0;
	localparam int REQ_DET_LSB = 2;
	localparam int REQ_INJ = 1;
	localparam int REQ_BW = 0;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FREEZE = 8'h04;
	localparam logic [7:0] ADDR_REQ = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_GAIN = 8'h14;
	localparam logic [7:0] ADDR_BANK = 8'h40;
	localparam int CTRL_LEGACY = 0;
	localparam int CTRL_SW_LSB = 1;
	localparam int CTRL_DR_AM = 3;
	localparam int CTRL_RESTART = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [15:0] FREEZE_RESET = 16'h0010;
	localparam logic [5:0] BANK_A_BASE = 6'h00;
	localparam logic [5:0] BANK_B_BASE = 6'h10;
	localparam logic [5:0] BANK_C_BASE = 6'h18;
	localparam logic [5:0] BANK_D_BASE = 6'h1C;
	localparam int BANK_ENTRIES = 32;
	localparam logic [11:0] BANK_WIDTH_MASK_A = 12'hFFF;
	localparam logic [11:0] BANK_WIDTH_MASK_B = 12'h7FF;
	localparam logic [11:0] BANK_WIDTH_MASK_CD = 12'h3FF;
	localparam logic [3:0] MU_START_SHIFT = 4'h4;
	localparam logic [3:0] MU_FINAL_SHIFT = 4'hA;
	localparam logic [9:0] MU_STEP_SAMPLES = 10'h3FF;
	localparam int NORM_AVG_SHIFT = 4;
	localparam int CLK_MHZ = 25;
	localparam int LINK_IDLE_NS = 2000;
	localparam int LINK_IDLE_CYCLES = (LINK_IDLE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ### pdc_iq_correction_tuner_link.sv
/*
  back end of the primary decimation chain: adaptive image/quadrature
  corrector, output stream selection and the two-line tuner control link.
  assumes 650 kSa/s complex wanted/image input pairs, link pins synchronous
  to pclk, and an apb master for the registers.
*/
// How it works
// - correlate wanted with image, cancel leakage
// - normalization only inside adaptation engine
// - normalize in 6 dB shifts, averaged power
// - four complex correction coefficients
// - step size ramps automatically at startup
// - adaptation halts below freeze level after startup
// - legacy mode bypasses the corrector
// - software output: 650, 325, pair 325
// - digital radio output: wanted, fm or am
// - all sample streams are complex
// - tuner sends commands, device sends requests
// - commands always executed, requests optional; legacy mode ignores link commands
// - gain fields set gain compensation
// - bits 5 and 4 clear detectors
// - command word 23 bits, top five reserved
// - gain indexes at bits 17 to 7
// - low command bits layout as listed
// - request word 7 bits layout
// - legacy mode uses two gain bits
// - banks of 16, 8, 4, 4 entries
// - inputs arrive at 650 kSa/s
`timescale 1ns/10ps
module pdc_iq_correction_tuner_link (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pdc_pkg::pair_type in_pair,
	input wire logic in_valid,
	input wire pdc_pkg::cplx_type am_in,
	input wire logic am_valid,
	output pdc_pkg::pair_type sw_out,
	output logic sw_valid,
	output pdc_pkg::cplx_type dr_out,
	output logic dr_valid,
	input wire logic link_clk,
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe,
	input wire logic [1:0] legacy_if_gain,
	input wire logic [1:0] if_level_result,
	output logic [13:0] gain_compensation,
	output logic if_detector_clear,
	output logic linear_detector_clear,
	output logic injection_side,
	output logic bandwidth_select
);
	import pdc_pkg::*;

	function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
		if (v > 36'sd32767)
			sat16 = 16'sh7FFF;
		else if (v < -36'sd32768)
			sat16 = -16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	function automatic logic [4:0] msb_pos(input logic [31:0] v);
		msb_pos = 5'h00;
		for (int b = 0; b < 32; b++) begin
			if (v[b])
				msb_pos = b[4:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and apb slave
	logic [4:0] ctrl;
	logic [15:0] freeze_level;
	logic [1:0] req_word;
	logic [22:0] last_cmd;
	logic [11:0] bank [BANK_ENTRIES];
	logic restart;
	logic [3:0] mu_shift;
	logic [4:0] norm_shift;
	adapt_state_type adapt_state;
	logic legacy;
	logic wr_en;
	logic bank_hit;
	logic [7:0] bank_off;
	logic [4:0] bank_idx;
	assign legacy = ctrl[CTRL_LEGACY];
	assign wr_en = psel & penable & pready & pwrite;
	assign bank_hit = (paddr >= ADDR_BANK) && (paddr < ADDR_BANK + 8'h80) && (paddr[1:0] == 2'b00);
	// entry index counts from the base of the bank window
	assign bank_off = paddr - ADDR_BANK;
	assign bank_idx = bank_off[6:2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel & ~penable) begin
				case (paddr)
					ADDR_CTRL: prdata <= {27'h0, ctrl};
					ADDR_FREEZE: prdata <= {16'h0, freeze_level};
					ADDR_REQ: prdata <= {30'h0, req_word};
					ADDR_STATUS: prdata <= {17'h0, norm_shift, mu_shift, if_level_result,
						injection_side, bandwidth_select, adapt_state};
					ADDR_CMD: prdata <= {9'h0, last_cmd};
					ADDR_GAIN: prdata <= {18'h0, gain_compensation};
					default: begin
						if (bank_hit)
							prdata <= {20'h0, bank[bank_idx]};
						else
							pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			freeze_level <= FREEZE_RESET;
			req_word <= 2'b00;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			if (wr_en && paddr == ADDR_CTRL) begin
				ctrl <= {1'b0, pwdata[3:0]};
				restart <= pwdata[CTRL_RESTART];
			end
			if (wr_en && paddr == ADDR_FREEZE)
				freeze_level <= pwdata[15:0];
			if (wr_en && paddr == ADDR_REQ)
				req_word <= pwdata[1:0];
		end
	end

	// gain banks, each entry clipped to its bank's width
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int e = 0; e < BANK_ENTRIES; e++)
				bank[e] <= 12'h000;
		end else if (wr_en && bank_hit) begin
			if (bank_idx < BANK_B_BASE[4:0])
				bank[bank_idx] <= pwdata[11:0] & BANK_WIDTH_MASK_A;
			else if (bank_idx < BANK_C_BASE[4:0])
				bank[bank_idx] <= pwdata[11:0] & BANK_WIDTH_MASK_B;
			else
				bank[bank_idx] <= pwdata[11:0] & BANK_WIDTH_MASK_CD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tuner control link
	logic clk_q;
	logic clk_rise;
	logic clk_fall;
	logic [4:0] bit_cnt;
	logic [5:0] idle_cnt;
	logic [22:0] shift_in;
	logic [6:0] req_shift;
	logic cmd_done;
	logic [22:0] cmd;
	assign clk_rise = link_clk & ~clk_q;
	assign clk_fall = ~link_clk & clk_q;
	assign cmd = {shift_in[21:0], link_data_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			bit_cnt <= 5'h00;
			idle_cnt <= 6'h00;
			shift_in <= 23'h000000;
			req_shift <= 7'h00;
			link_data_out <= 1'b0;
			link_data_oe <= 1'b0;
			cmd_done <= 1'b0;
			last_cmd <= 23'h000000;
		end else begin
			clk_q <= link_clk;
			cmd_done <= 1'b0;
			if (legacy) begin
				bit_cnt <= 5'h00;
				link_data_oe <= 1'b0;
			end else if (clk_rise || clk_fall) begin
				idle_cnt <= 6'h00;
			end else if (idle_cnt == LINK_IDLE_CYCLES[5:0]) begin
				bit_cnt <= 5'h00;
				link_data_oe <= 1'b0;
			end else begin
				idle_cnt <= idle_cnt + 6'h01;
			end
			if (!legacy && clk_rise) begin
				if (bit_cnt < CMD_BITS[4:0]) begin
					shift_in <= cmd;
					if (bit_cnt == CMD_BITS[4:0] - 5'h01) begin
						cmd_done <= 1'b1;
						last_cmd <= {5'h00, cmd[CMD_RSV_LSB-1:0]};
						req_shift <= {3'b000, if_level_result, req_word};
					end
				end
				if (bit_cnt < FRAME_BITS[4:0] - 5'h01)
					bit_cnt <= bit_cnt + 5'h01;
				else
					bit_cnt <= 5'h00;
			end
			if (!legacy && clk_fall) begin
				if (bit_cnt >= CMD_BITS[4:0] && bit_cnt < FRAME_BITS[4:0]) begin
					link_data_oe <= 1'b1;
					link_data_out <= req_shift[REQ_BITS-1];
					req_shift <= {req_shift[5:0], 1'b0};
				end else begin
					link_data_oe <= 1'b0;
				end
			end
		end
	end

	// command execution: on arrival; gain d, injection and bandwidth only when their qualifier bit is set
	logic [3:0] idx_a;
	logic [2:0] idx_b;
	logic [1:0] idx_c;
	logic [1:0] idx_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_a <= 4'h0;
			idx_b <= 3'h0;
			idx_c <= 2'h0;
			idx_d <= 2'h0;
			injection_side <= 1'b0;
			bandwidth_select <= 1'b0;
			if_detector_clear <= 1'b0;
			linear_detector_clear <= 1'b0;
		end else begin
			if_detector_clear <= 1'b0;
			linear_detector_clear <= 1'b0;
			if (legacy) begin
				idx_d <= legacy_if_gain;
			end else if (cmd_done) begin
				idx_a <= last_cmd[CMD_A_LSB+3:CMD_A_LSB];
				idx_b <= last_cmd[CMD_B_LSB+2:CMD_B_LSB];
				idx_c <= last_cmd[CMD_C_LSB+1:CMD_C_LSB];
				if (last_cmd[CMD_DQ])
					idx_d <= last_cmd[CMD_D_LSB+1:CMD_D_LSB];
				if_detector_clear <= last_cmd[CMD_DET];
				linear_detector_clear <= last_cmd[CMD_LIN];
				if (last_cmd[CMD_INJQ])
					injection_side <= last_cmd[CMD_INJ];
				if (last_cmd[CMD_BWQ])
					bandwidth_select <= last_cmd[CMD_BW];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gain_compensation <= 14'h0000;
		else
			gain_compensation <= {2'b00, bank[{1'b0, idx_a} + BANK_A_BASE[4:0]]}
				+ {2'b00, bank[{2'b00, idx_b} + BANK_B_BASE[4:0]]}
				+ {2'b00, bank[{3'b000, idx_c} + BANK_C_BASE[4:0]]}
				+ {2'b00, bank[{3'b000, idx_d} + BANK_D_BASE[4:0]]};
	end

	////////////////////////////////////////////////////////////////////////
	// image/quadrature corrector
	cplx_type x_tap [TAPS];
	logic signed [15:0] c_re [TAPS];
	logic signed [15:0] c_im [TAPS];
	logic signed [35:0] acc_re [TAPS+1];
	logic signed [35:0] acc_im [TAPS+1];
	logic signed [35:0] err_re;
	logic signed [35:0] err_im;
	logic [31:0] power;
	logic [31:0] inst_power;
	logic [9:0] mu_cnt;
	logic adapt_on;
	assign x_tap[0] = in_pair.image;
	assign acc_re[0] = 36'sd0;
	assign acc_im[0] = 36'sd0;
	assign inst_power = 32'(in_pair.image.i * in_pair.image.i + in_pair.image.q * in_pair.image.q);
	assign err_re = 36'(in_pair.wanted.i) - (acc_re[TAPS] >>> 15);
	assign err_im = 36'(in_pair.wanted.q) - (acc_im[TAPS] >>> 15);
	assign adapt_on = in_valid && (adapt_state == ADAPT_STARTUP || adapt_state == ADAPT_TRACK);

	genvar k;
	generate
		for (k = 0; k < TAPS; k++) begin : g_tap
			logic signed [35:0] grad_re;
			logic signed [35:0] grad_im;
			logic signed [35:0] step_re;
			logic signed [35:0] step_im;
			assign acc_re[k+1] = acc_re[k] + 36'(c_re[k] * x_tap[k].i - c_im[k] * x_tap[k].q);
			assign acc_im[k+1] = acc_im[k] + 36'(c_re[k] * x_tap[k].q + c_im[k] * x_tap[k].i);
			assign grad_re = 36'(sat16(err_re) * x_tap[k].i + sat16(err_im) * x_tap[k].q);
			assign grad_im = 36'(sat16(err_im) * x_tap[k].i - sat16(err_re) * x_tap[k].q);
			assign step_re = grad_re >>> (6'd15 + {2'b00, mu_shift} + {1'b0, norm_shift});
			assign step_im = grad_im >>> (6'd15 + {2'b00, mu_shift} + {1'b0, norm_shift});
			if (k > 0) begin : g_delay
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn)
						x_tap[k] <= '0;
					else if (in_valid)
						x_tap[k] <= x_tap[k-1];
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					c_re[k] <= 16'sh0000;
					c_im[k] <= 16'sh0000;
				end else if (restart) begin
					c_re[k] <= 16'sh0000;
					c_im[k] <= 16'sh0000;
				end else if (adapt_on) begin
					c_re[k] <= sat16(36'(c_re[k]) + step_re);
					c_im[k] <= sat16(36'(c_im[k]) + step_im);
				end
			end
		end
	endgenerate

	// averaged image power sets the normalization shift, one bit per 6 dB
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power <= 32'h0000_0000;
			norm_shift <= 5'h00;
		end else if (in_valid) begin
			power <= power + ((inst_power >> NORM_AVG_SHIFT) - (power >> NORM_AVG_SHIFT));
			norm_shift <= msb_pos(power >> 15);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapt_state <= ADAPT_IDLE;
			mu_shift <= MU_START_SHIFT;
			mu_cnt <= 10'h000;
		end else begin
			case (adapt_state)
				ADAPT_IDLE: begin
					mu_shift <= MU_START_SHIFT;
					mu_cnt <= 10'h000;
					if (!legacy)
						adapt_state <= ADAPT_STARTUP;
				end
				ADAPT_STARTUP: begin
					if (in_valid) begin
						mu_cnt <= mu_cnt + 10'h001;
						if (mu_cnt == MU_STEP_SAMPLES) begin
							mu_shift <= mu_shift + 4'h1;
							if (mu_shift == MU_FINAL_SHIFT - 4'h1)
								adapt_state <= ADAPT_TRACK;
						end
					end
				end
				ADAPT_TRACK: begin
					if (in_valid && power[31:15] < {1'b0, freeze_level})
						adapt_state <= ADAPT_FROZEN;
				end
				ADAPT_FROZEN: begin
					if (in_valid && power[31:15] >= {1'b0, freeze_level})
						adapt_state <= ADAPT_TRACK;
				end
				default: adapt_state <= ADAPT_IDLE;
			endcase
			if (legacy || restart)
				adapt_state <= ADAPT_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output stream selection
	cplx_type corrected;
	cplx_type wanted_hold;
	logic phase;
	always_comb begin
		if (legacy) begin
			corrected = in_pair.wanted;
		end else begin
			corrected.i = sat16(err_re);
			corrected.q = sat16(err_im);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_out <= '0;
			sw_valid <= 1'b0;
			phase <= 1'b0;
			wanted_hold <= '0;
		end else begin
			sw_valid <= 1'b0;
			if (in_valid) begin
				phase <= ~phase;
				wanted_hold <= corrected;
				case (ctrl[CTRL_SW_LSB+1:CTRL_SW_LSB])
					2'b00: begin
						sw_out <= {corrected, 32'h0000_0000};
						sw_valid <= 1'b1;
					end
					2'b01: begin
						if (phase) begin
							sw_out.wanted.i <= sat16((36'(wanted_hold.i) + 36'(corrected.i)) >>> 1);
							sw_out.wanted.q <= sat16((36'(wanted_hold.q) + 36'(corrected.q)) >>> 1);
							sw_out.image <= '0;
							sw_valid <= 1'b1;
						end
					end
					2'b10: begin
						if (phase) begin
							sw_out <= {corrected, in_pair.image};
							sw_valid <= 1'b1;
						end
					end
					default: sw_valid <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dr_out <= '0;
			dr_valid <= 1'b0;
		end else if (ctrl[CTRL_DR_AM]) begin
			dr_out <= am_in;
			dr_valid <= am_valid;
		end else begin
			dr_out <= corrected;
			dr_valid <= in_valid;
		end
	end
endmodule

// ### tuner_model.sv
/*
  behavioural tuner on the two-line control link: sends one 23-bit command
  and collects the 7-bit request of each 30-clock frame.
  assumes pclk at 25 MHz and a bench that pulses start.
*/
`timescale 1ns/10ps
module tuner_model (
	input wire logic pclk,
	input wire logic start,
	input wire logic [22:0] cmd,
	input wire logic dev_oe,
	input wire logic dev_out,
	output logic link_clk,
	output logic line,
	output logic busy,
	output logic [6:0] req
);
	logic drv;
	assign line = dev_oe ? dev_out : drv;
	initial begin
		link_clk = 0;
		drv = 0;
		busy = 0;
		req = 0;
		forever begin
			@(posedge pclk);
			if (start) begin
				busy <= 1;
				for (int b = 29; b >= 0; b--) begin
					// command msb first, then the released line toggles
					if (b > 6) drv <= cmd[b-7];
					else drv <= ~drv;
					repeat (4) @(posedge pclk);
					link_clk <= 1;
					// requests are only recorded, never obeyed
					if (b < 7) req[b] <= line;
					repeat (4) @(posedge pclk);
					link_clk <= 0;
				end
				busy <= 0;
			end else begin
				drv <= ~drv;
			end
		end
	end
endmodule

// ### pdc_iq_correction_tuner_link_asserts.sv
/*
  port checker of the decimation back end.
  assumes one pclk domain and is bound to every instance.
*/
`timescale 1ns/10ps
module pdc_iq_correction_tuner_link_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic in_valid,
	input wire logic am_valid,
	input wire logic sw_valid,
	input wire logic dr_valid,
	input wire logic link_clk,
	input wire logic link_data_oe,
	input wire logic if_detector_clear,
	input wire logic linear_detector_clear,
	input wire logic injection_side,
	input wire logic bandwidth_select
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_OE_AFTER_FALL: assert property ($rose(link_data_oe) |-> !link_clk && !$past(link_clk))
		else $error("request drive not after a fall");
	AST_DET_PULSE: assert property (if_detector_clear |=> !if_detector_clear)
		else $error("detector clear too long");
	AST_LIN_PULSE: assert property (linear_detector_clear |=> !linear_detector_clear)
		else $error("linear clear too long");
	AST_SW_CAUSE: assert property (sw_valid |-> $past(in_valid))
		else $error("software sample without input");
	AST_DR_CAUSE: assert property (dr_valid |-> $past(in_valid) || $past(am_valid))
		else $error("radio sample without input");
	AST_INJ_BY_LINK: assert property ($changed(injection_side) |-> $past(link_clk, 2))
		else $error("injection changed off a command");
	AST_BW_BY_LINK: assert property ($changed(bandwidth_select) |-> $past(link_clk, 2))
		else $error("bandwidth changed off a command");
endmodule
bind pdc_iq_correction_tuner_link pdc_iq_correction_tuner_link_asserts i_asserts (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .in_valid, .am_valid,
	.sw_valid, .dr_valid, .link_clk, .link_data_oe, .if_detector_clear,
	.linear_detector_clear, .injection_side, .bandwidth_select
);

// ### pdc_iq_correction_tuner_link_bench.sv
/*
  self-checking bench of the decimation back end.
  assumes the tuner model and the bound checker.
*/
`timescale 1ns/10ps
module pdc_iq_correction_tuner_link_bench;
	import pdc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic pready, pslverr, rerr, sw_valid, dr_valid, link_clk, line, link_data_out;
	pair_type in_pair = 0, sw_out, pr;
	cplx_type am_in = 0, dr_out, ai;
	logic in_valid = 0, am_valid = 0, start = 0, busy, link_data_oe;
	logic [1:0] legacy_if_gain = 0, if_level_result = 0;
	logic [13:0] gain_compensation;
	logic if_detector_clear, linear_detector_clear, injection_side, bandwidth_select;
	logic [22:0] cmd = 0;
	logic [6:0] rq_got;
	logic [11:0] bank [32];
	logic ei = 0, eb = 0;
	int ia = 0, ib = 0, ic = 0, id = 0, dcnt = 0, lcnt = 0, sc = 0, cyc = 0, seed;
	int failures = 0, total_checks = 0;
	int exp_sw [4] = '{8, 4, 4, 0};
	always #20 pclk = ~pclk;
	pdc_iq_correction_tuner_link i_pdc_iq_correction_tuner_link (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .in_pair, .in_valid, .am_in, .am_valid, .sw_out, .sw_valid, .dr_out,
		.dr_valid, .link_clk, .link_data_in(line), .link_data_out, .link_data_oe,
		.legacy_if_gain, .if_level_result, .gain_compensation, .if_detector_clear,
		.linear_detector_clear, .injection_side, .bandwidth_select
	);
	tuner_model i_tuner_model (
		.pclk, .start, .cmd, .dev_oe(link_data_oe), .dev_out(link_data_out),
		.link_clk, .line, .busy, .req(rq_got)
	);
	always @(posedge pclk) begin
		cyc++;
		if (if_detector_clear === 1'b1) dcnt++;
		if (linear_detector_clear === 1'b1) lcnt++;
		if (sw_valid === 1'b1) sc++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e, input string m);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic frame(input logic [22:0] c, input logic lg);
		int d0 = dcnt;
		int l0 = lcnt;
		logic [1:0] rq = 2'($urandom);
		apb(1, ADDR_REQ, {30'h0, rq});
		if_level_result <= 2'($urandom);
		legacy_if_gain <= 2'($urandom);
		cmd <= c;
		start <= 1;
		@(posedge pclk);
		start <= 0;
		@(posedge pclk);
		while (busy) @(posedge pclk);
		repeat (60) @(posedge pclk);
		if (!lg) begin
			ia = c[17:14];
			ib = c[13:11];
			ic = c[10:9];
			if (c[6]) id = c[8:7];
			if (c[2]) ei = c[3];
			if (c[0]) eb = c[1];
			chk(rq_got, {3'h0, if_level_result, rq}, "request");
			chk(dcnt - d0, c[5], "detector clear");
			chk(lcnt - l0, c[4], "linear clear");
			apb(0, ADDR_CMD, 0);
			chk(rdat, c & 23'h03FFFF, "command");
		end else
			id = legacy_if_gain;
		chk(gain_compensation, bank[ia] + bank[16+ib] + bank[24+ic] + bank[28+id], "gain");
		chk(injection_side, ei, "injection");
		chk(bandwidth_select, eb, "bandwidth");
	endtask
	initial begin
		seed = $urandom(18);
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, ADDR_FREEZE, 0);
		chk(rdat, FREEZE_RESET, "freeze reset");
		apb(0, ADDR_CTRL, 0);
		chk(rdat, CTRL_RESET, "ctrl reset");
		apb(0, ADDR_STATUS, 0);
		chk(rdat, {22'h0, MU_START_SHIFT, 6'h01}, "startup step");
		apb(0, 8'h22, 0);
		chk({rdat, rerr}, 1, "unmapped");
		for (int k = 0; k < 32; k++) begin
			rdat = $urandom;
			bank[k] = rdat[11:0] & (k < 16 ? BANK_WIDTH_MASK_A :
				k < 24 ? BANK_WIDTH_MASK_B : BANK_WIDTH_MASK_CD);
			apb(1, ADDR_BANK + 8'(4 * k), rdat);
			apb(0, ADDR_BANK + 8'(4 * k), 0);
			chk(rdat, bank[k], "bank");
		end
		frame(23'h7FFFFF, 0);
		frame(23'h0, 0);
		repeat (12) frame(23'($urandom), 0);
		for (int m = 0; m < 4; m++) begin
			apb(1, ADDR_CTRL, 32'(m * 2 + m % 2 * 8 + 1));
			sc = 0;
			for (int k = 0; k < 8; k++) begin
				pr = {$urandom, $urandom};
				ai = $urandom;
				in_pair <= pr;
				am_in <= ai;
				in_valid <= 1;
				am_valid <= 1;
				@(posedge pclk);
				in_valid <= 0;
				am_valid <= 0;
				@(posedge pclk);
				if (m == 0) chk(sw_out, {pr.wanted, 32'h0}, "bypass");
				chk({dr_out, dr_valid}, {m % 2 ? ai : pr.wanted, 1'b1}, "radio out");
				repeat (3) @(posedge pclk);
			end
			chk(sc, exp_sw[m], "stream rate");
		end
		frame(23'($urandom), 1);
		apb(1, ADDR_CTRL, 32'h11);
		apb(0, ADDR_CTRL, 0);
		chk(rdat, 32'h1, "restart");
		// corrector path with cleared taps passes the wanted sample unchanged
		apb(1, ADDR_CTRL, 0);
		pr = {$urandom, $urandom};
		in_pair <= pr;
		in_valid <= 1;
		@(posedge pclk);
		in_valid <= 0;
		@(posedge pclk);
		chk(sw_out, {pr.wanted, 32'h0}, "zero taps");
		chk(dr_out, pr.wanted, "radio fm corrected");
		summarize();
	end
endmodule
